// [common/cstc_defs.vh]
// Constants for the battery short and termination configuration block
`ifndef CSTC_DEFS_VH
`define CSTC_DEFS_VH

// ==========================================
// Register addresses
`define CSTC_ADDR_FAULT        8'h0d
`define CSTC_ADDR_SHORT_CFG    8'h10
`define CSTC_ADDR_TERM_CFG     8'h11

// ==========================================
// Field positions
`define CSTC_TIMEOUT_MSB       7
`define CSTC_TIMEOUT_LSB       5
`define CSTC_VOLT_MSB          2
`define CSTC_VOLT_LSB          0
`define CSTC_TERM_MSB          7
`define CSTC_TERM_LSB          5
`define CSTC_DIV20_BIT         4
`define CSTC_DIV10_BIT         3
`define CSTC_DIV5_BIT          2
`define CSTC_MODE_MSB          1
`define CSTC_MODE_LSB          0
`define CSTC_FAULT_SHORT_BIT   3

// ==========================================
// Reset values and short config write mask
`define CSTC_SHORT_CFG_RST     8'h84
`define CSTC_TERM_CFG_RST      8'h40
`define CSTC_SHORT_CFG_MASK    8'he7

// ==========================================
// System enable modes
`define CSTC_MODE_LDO          2'h0
`define CSTC_MODE_BATNODE      2'h1
`define CSTC_MODE_WEAKISO      2'h2
`define CSTC_MODE_CHGWEAK      2'h3

// ==========================================
// Short timeouts in seconds
`define CSTC_TO_0              8'h01
`define CSTC_TO_1              8'h02
`define CSTC_TO_2              8'h04
`define CSTC_TO_3              8'h0a
`define CSTC_TO_4              8'h1e
`define CSTC_TO_5              8'h3c
`define CSTC_TO_6              8'h78
`define CSTC_TO_7              8'hb4

// ==========================================
// Termination current, 0.1 mA units, and ratio divisors
`define CSTC_TERM_0            11'd125
`define CSTC_TERM_1            11'd325
`define CSTC_TERM_2            11'd525
`define CSTC_TERM_3            11'd725
`define CSTC_TERM_4            11'd925
`define CSTC_TERM_5            11'd1175
`define CSTC_TERM_6            11'd1425
`define CSTC_TERM_7            11'd1700
`define CSTC_TERM_MIN          16'd125
`define CSTC_TERM_MAX          16'd1700
`define CSTC_DIV20             16'd20
`define CSTC_DIV10             16'd10
`define CSTC_DIV5              16'd5

// ==========================================
// Timing, bus device address and fast charge current scaling
`define CSTC_CLK_HZ            28'd200000000
`define CSTC_TICK_SEC          28'd1
`define CSTC_SEC_CYCLES        (`CSTC_CLK_HZ * `CSTC_TICK_SEC)
`define CSTC_DEV_ADDR          7'h14
`define CSTC_ICHG_BASE_X10     16'd1000
`define CSTC_ICHG_STEP_X10     16'd500

`endif

// [src/cstc_serial_slave.v]
// Serial management bus slave with byte register port
`timescale 1ns/1ps
`include "cstc_defs.vh"

module cstc_serial_slave #(
	parameter [6:0] DEV_ADDR = `CSTC_DEV_ADDR
) (
	// Clock and reset
	input  wire       clk,
	input  wire       reset_n,
	// Bus pins
	input  wire       scl,
	input  wire       sdaIn,
	output reg        sdaOut,
	output reg        sdaOe,
	// Register port
	output reg        wrStrobe,
	output reg  [7:0] wrAddr,
	output reg  [7:0] wrData,
	output wire [7:0] rdAddr,
	input  wire [7:0] rdData
);

	// ==========================================
	// States
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_ADDR = 7'h02;
	localparam [6:0] S_ACKA = 7'h04;
	localparam [6:0] S_WRX  = 7'h08;
	localparam [6:0] S_ACKW = 7'h10;
	localparam [6:0] S_RDX  = 7'h20;
	localparam [6:0] S_ACKR = 7'h40;

	reg [6:0] state_reg;
	reg [3:0] bitCnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] ptr_reg;
	reg       rw_reg;
	reg       first_reg;
	reg       ack_reg;
	reg       sclPrev_reg;
	reg       sdaPrev_reg;

	wire sclRise = scl & ~sclPrev_reg;
	wire sclFall = ~scl & sclPrev_reg;
	wire startCond = scl & sclPrev_reg & sdaPrev_reg & ~sdaIn;
	wire stopCond = scl & sclPrev_reg & ~sdaPrev_reg & sdaIn;

	assign rdAddr = ptr_reg;

	// ==========================================
	// Protocol engine
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg   <= S_IDLE;
			bitCnt_reg  <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
			rw_reg      <= 1'b0;
			first_reg   <= 1'b0;
			ack_reg     <= 1'b0;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
			sdaOut      <= 1'b0;
			sdaOe       <= 1'b0;
			wrStrobe    <= 1'b0;
			wrAddr      <= 8'h00;
			wrData      <= 8'h00;
		end else begin
			sclPrev_reg <= scl;
			sdaPrev_reg <= sdaIn;
			sdaOut      <= 1'b0;
			wrStrobe    <= 1'b0;
			if (startCond) begin
				state_reg  <= S_ADDR;
				bitCnt_reg <= 4'h0;
				sdaOe      <= 1'b0;
			end else if (stopCond) begin
				state_reg <= S_IDLE;
				sdaOe     <= 1'b0;
			end else begin
				case (state_reg)
					S_ADDR, S_WRX: begin
						if (sclRise) begin
							shift_reg  <= {shift_reg[6:0], sdaIn};
							bitCnt_reg <= bitCnt_reg + 4'h1;
						end else if (sclFall && bitCnt_reg == 4'h8) begin
							if (state_reg == S_ADDR) begin
								if (shift_reg[7:1] == DEV_ADDR) begin
									sdaOe     <= 1'b1;
									rw_reg    <= shift_reg[0];
									state_reg <= S_ACKA;
								end else begin
									state_reg <= S_IDLE;
								end
							end else begin
								sdaOe     <= 1'b1;
								state_reg <= S_ACKW;
								first_reg <= 1'b0;
								if (first_reg) begin
									ptr_reg <= shift_reg;
								end else begin
									wrStrobe <= 1'b1;
									wrAddr   <= ptr_reg;
									wrData   <= shift_reg;
									ptr_reg  <= ptr_reg + 8'h01;
								end
							end
						end
					end
					S_ACKA: begin
						if (sclFall) begin
							bitCnt_reg <= 4'h0;
							if (rw_reg) begin
								shift_reg <= rdData;
								sdaOe     <= ~rdData[7];
								ptr_reg   <= ptr_reg + 8'h01;
								state_reg <= S_RDX;
							end else begin
								sdaOe     <= 1'b0;
								first_reg <= 1'b1;
								state_reg <= S_WRX;
							end
						end
					end
					S_ACKW: begin
						if (sclFall) begin
							sdaOe      <= 1'b0;
							bitCnt_reg <= 4'h0;
							state_reg  <= S_WRX;
						end
					end
					S_RDX: begin
						if (sclFall) begin
							if (bitCnt_reg == 4'h7) begin
								sdaOe     <= 1'b0;
								state_reg <= S_ACKR;
							end else begin
								bitCnt_reg <= bitCnt_reg + 4'h1;
								shift_reg  <= {shift_reg[6:0], 1'b0};
								sdaOe      <= ~shift_reg[6];
							end
						end
					end
					S_ACKR: begin
						if (sclRise) begin
							ack_reg <= ~sdaIn;
						end else if (sclFall) begin
							if (ack_reg) begin
								bitCnt_reg <= 4'h0;
								shift_reg  <= rdData;
								sdaOe      <= ~rdData[7];
								ptr_reg    <= ptr_reg + 8'h01;
								state_reg  <= S_RDX;
							end else begin
								state_reg <= S_IDLE;
							end
						end
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end
		end
	end

endmodule // cstc_serial_slave

// [src/cstc_charger_cfg.v]
// Battery short timing, termination current selection and system enable control
//
// Function
// R1: Short timeout field bits 7:5 selects 1..180 s, resets to 30 s.
// R2: Short voltage field bits 2:0 selects 2.0..2.7 V, resets to 2.4 V.
// R3: Termination table field bits 7:5, resets to 52.5 mA, used without ratio bits.
// R4: Divide-by-20 bit 4 uses fast charge current over 20, highest priority.
// R5: Divide-by-10 bit 3 applies when bit 4 clear, beats divide-by-5 and table.
// R6: Divide-by-5 bit 2 applies when bits 4 and 3 clear, beats table only.
// R7: Ratio results are clamped between 12.5 mA and 170 mA.
// R8: Mode field bits 1:0 resets to 00; 00 enables on regulator active and system voltage.
// R9: Mode 01 enables system from battery-side node voltage.
// R10: Mode 10 enables system and opens isolation switch below weak threshold.
// R11: Mode 10 applies only with input supply absent and battery monitor enabled.
// R12: Mode 11 enables in regulator mode when not charging, else at or above weak.
// R13: Short fault flag bit 3 of fault register sets on detected short, else 0.
// R14: Short fault stays until software writes one or input supply cycles.
// R15: Short declared after continuous undervoltage for timeout; recovery restarts timing.
`timescale 1ns/1ps
`include "cstc_defs.vh"

module cstc_charger_cfg #(
	parameter [27:0] SEC_CYCLES    = `CSTC_SEC_CYCLES,
	parameter [6:0]  DEV_ADDR      = `CSTC_DEV_ADDR,
	parameter [15:0] ICHG_BASE_X10 = `CSTC_ICHG_BASE_X10,
	parameter [15:0] ICHG_STEP_X10 = `CSTC_ICHG_STEP_X10
) (
	// Clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// Serial management bus
	input  wire        scl,
	input  wire        sdaIn,
	output wire        sdaOut,
	output wire        sdaOe,
	// Analog status
	input  wire        batBelowShort,
	input  wire        inputSupplyPresent,
	input  wire        ldoActive,
	input  wire        sysVoltageOk,
	input  wire        batteryNodeOk,
	input  wire        batAboveWeak,
	input  wire        chargeEnabled,
	input  wire        batteryMonitorEnable,
	input  wire [4:0]  fastChargeCurrentSel,
	// Analog controls
	output reg  [2:0]  shortVoltageSel,
	output reg  [10:0] termCurrentX10,
	output reg         systemEnableOutput,
	output reg         isoSwitchDisable,
	output reg         batteryShortFault
);

	// ==========================================
	// Register port
	wire       wrStrobe;
	wire [7:0] wrAddr;
	wire [7:0] wrData;
	wire [7:0] rdAddr;
	reg  [7:0] rdData;
	reg  [7:0] shortCfg_reg;
	reg  [7:0] termCfg_reg;

	cstc_serial_slave #(
		.DEV_ADDR (DEV_ADDR)
	) cstc_serial_slave_inst (
		.clk      (clk),
		.reset_n  (reset_n),
		.scl      (scl),
		.sdaIn    (sdaIn),
		.sdaOut   (sdaOut),
		.sdaOe    (sdaOe),
		.wrStrobe (wrStrobe),
		.wrAddr   (wrAddr),
		.wrData   (wrData),
		.rdAddr   (rdAddr),
		.rdData   (rdData)
	);

	// ==========================================
	// Configuration registers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shortCfg_reg <= `CSTC_SHORT_CFG_RST; // [R1] [R2]
			termCfg_reg  <= `CSTC_TERM_CFG_RST;  // [R3] [R8]
		end else if (wrStrobe) begin
			if (wrAddr == `CSTC_ADDR_SHORT_CFG) begin
				shortCfg_reg <= wrData & `CSTC_SHORT_CFG_MASK; // [R1] [R2]
			end
			if (wrAddr == `CSTC_ADDR_TERM_CFG) begin
				termCfg_reg <= wrData; // [R3] [R8]
			end
		end
	end

	always @* begin
		case (rdAddr)
			`CSTC_ADDR_SHORT_CFG: rdData = shortCfg_reg;
			`CSTC_ADDR_TERM_CFG:  rdData = termCfg_reg;
			`CSTC_ADDR_FAULT:     rdData = {4'h0, batteryShortFault, 3'h0}; // [R13]
			default:              rdData = 8'h00;
		endcase
	end

	wire [2:0] timeoutSel = shortCfg_reg[`CSTC_TIMEOUT_MSB:`CSTC_TIMEOUT_LSB];
	wire [2:0] termSel    = termCfg_reg[`CSTC_TERM_MSB:`CSTC_TERM_LSB];
	wire [1:0] modeSel    = termCfg_reg[`CSTC_MODE_MSB:`CSTC_MODE_LSB];

	// ==========================================
	// Short timeout lookup
	reg [7:0] timeoutSec;
	always @* begin
		case (timeoutSel) // [R1]
			3'h0:    timeoutSec = `CSTC_TO_0;
			3'h1:    timeoutSec = `CSTC_TO_1;
			3'h2:    timeoutSec = `CSTC_TO_2;
			3'h3:    timeoutSec = `CSTC_TO_3;
			3'h4:    timeoutSec = `CSTC_TO_4;
			3'h5:    timeoutSec = `CSTC_TO_5;
			3'h6:    timeoutSec = `CSTC_TO_6;
			default: timeoutSec = `CSTC_TO_7;
		endcase
	end

	// ==========================================
	// Short detection and fault flag
	reg [27:0] preCnt_reg;
	reg [7:0]  secCnt_reg;
	reg        supplyPrev_reg;
	wire       secTick = (preCnt_reg == SEC_CYCLES - 28'h1);
	wire       shortTrip = batBelowShort && secTick && (secCnt_reg + 8'h01 >= timeoutSec);
	wire       faultClear = (wrStrobe && wrAddr == `CSTC_ADDR_FAULT && wrData[`CSTC_FAULT_SHORT_BIT])
	                        || (supplyPrev_reg && !inputSupplyPresent);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preCnt_reg        <= 28'h0000000;
			secCnt_reg        <= 8'h00;
			supplyPrev_reg    <= 1'b0;
			batteryShortFault <= 1'b0;
		end else begin
			supplyPrev_reg <= inputSupplyPresent;
			if (!batBelowShort) begin
				preCnt_reg <= 28'h0000000; // [R15]
				secCnt_reg <= 8'h00;       // [R15]
			end else if (secTick) begin
				preCnt_reg <= 28'h0000000;
				if (secCnt_reg != 8'hff) begin
					secCnt_reg <= secCnt_reg + 8'h01; // [R15]
				end
			end else begin
				preCnt_reg <= preCnt_reg + 28'h0000001;
			end
			if (shortTrip) begin
				batteryShortFault <= 1'b1; // [R13] [R15]
			end else if (faultClear) begin
				batteryShortFault <= 1'b0; // [R14]
			end
		end
	end

	// ==========================================
	// Termination current selection
	wire [15:0] ichgX10 = ICHG_BASE_X10 + ICHG_STEP_X10 * {11'h000, fastChargeCurrentSel};
	reg  [15:0] ratioX10;
	reg  [15:0] clampX10;
	reg  [10:0] tableX10;
	reg  [10:0] termNext;
	wire        ratioOn = termCfg_reg[`CSTC_DIV20_BIT] | termCfg_reg[`CSTC_DIV10_BIT]
	                      | termCfg_reg[`CSTC_DIV5_BIT];

	always @* begin
		case (termSel) // [R3]
			3'h0:    tableX10 = `CSTC_TERM_0;
			3'h1:    tableX10 = `CSTC_TERM_1;
			3'h2:    tableX10 = `CSTC_TERM_2;
			3'h3:    tableX10 = `CSTC_TERM_3;
			3'h4:    tableX10 = `CSTC_TERM_4;
			3'h5:    tableX10 = `CSTC_TERM_5;
			3'h6:    tableX10 = `CSTC_TERM_6;
			default: tableX10 = `CSTC_TERM_7;
		endcase
		if (termCfg_reg[`CSTC_DIV20_BIT]) begin
			ratioX10 = ichgX10 / `CSTC_DIV20; // [R4]
		end else if (termCfg_reg[`CSTC_DIV10_BIT]) begin
			ratioX10 = ichgX10 / `CSTC_DIV10; // [R5]
		end else begin
			ratioX10 = ichgX10 / `CSTC_DIV5; // [R6]
		end
		if (ratioX10 < `CSTC_TERM_MIN) begin
			clampX10 = `CSTC_TERM_MIN; // [R7]
		end else if (ratioX10 > `CSTC_TERM_MAX) begin
			clampX10 = `CSTC_TERM_MAX; // [R7]
		end else begin
			clampX10 = ratioX10;
		end
		termNext = ratioOn ? clampX10[10:0] : tableX10; // [R3]
	end

	// ==========================================
	// System enable logic
	reg sysEnNext;
	reg isoOffNext;
	always @* begin
		sysEnNext  = 1'b0;
		isoOffNext = 1'b0;
		case (modeSel)
			`CSTC_MODE_LDO: begin
				sysEnNext = ldoActive & sysVoltageOk; // [R8]
			end
			`CSTC_MODE_BATNODE: begin
				sysEnNext = batteryNodeOk; // [R9]
			end
			`CSTC_MODE_WEAKISO: begin
				if (!inputSupplyPresent && batteryMonitorEnable) begin // [R11]
					sysEnNext  = ~batAboveWeak; // [R10]
					isoOffNext = ~batAboveWeak; // [R10]
				end else begin
					sysEnNext = ldoActive & sysVoltageOk;
				end
			end
			`CSTC_MODE_CHGWEAK: begin
				sysEnNext = chargeEnabled ? batAboveWeak : ldoActive; // [R12]
			end
			default: begin
				sysEnNext = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Registered outputs
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shortVoltageSel    <= 3'h4;
			termCurrentX10     <= `CSTC_TERM_2;
			systemEnableOutput <= 1'b0;
			isoSwitchDisable   <= 1'b0;
		end else begin
			shortVoltageSel    <= shortCfg_reg[`CSTC_VOLT_MSB:`CSTC_VOLT_LSB]; // [R2]
			termCurrentX10     <= termNext;
			systemEnableOutput <= sysEnNext;
			isoSwitchDisable   <= isoOffNext;
		end
	end

endmodule // cstc_charger_cfg

// [verification/cstc_host_model.sv]
// Host processor model that masters the serial management bus
`timescale 1ns/1ps

module cstc_host_model (
	// Clock
	input  wire clk,
	// Bus lines
	output reg  scl,
	output reg  sdaLow,
	input  wire sdaLine
);
	// ==========================================
	// Bus phases
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	// Each bus phase lasts four clocks, above the one clock the slave needs
	task step;
		begin
			repeat (4) @(posedge clk);
			#1;
		end
	endtask

	task start;
		begin
			sdaLow = 1'b0;
			step;
			scl = 1'b1;
			step;
			sdaLow = 1'b1;
			step;
			scl = 1'b0;
			step;
		end
	endtask

	task stop;
		begin
			sdaLow = 1'b1;
			step;
			scl = 1'b1;
			step;
			sdaLow = 1'b0;
			step;
		end
	endtask

	// Sends d MSB first, then a ninth bit b; returns the wire level of each bit
	task xbyte(input [7:0] d, input b, output [7:0] q, output r);
		integer i;
		begin
			for (i = 8; i >= 0; i--) begin
				sdaLow = (i == 0) ? !b : !d[i - 1];
				step;
				scl = 1'b1;
				step;
				if (i == 0)
					r = sdaLine;
				else
					q[i - 1] = sdaLine;
				scl = 1'b0;
				step;
			end
		end
	endtask
endmodule // cstc_host_model

// [verification/cstc_charger_cfg_properties.sv]
// Concurrent checks on the charger configuration top ports
`timescale 1ns/1ps

module cstc_charger_cfg_properties #(
	parameter [27:0] SEC_CYCLES = 28'd200000000
) (
	// Clock and reset
	input wire        clk,
	input wire        reset_n,
	// Inputs watched
	input wire        scl,
	input wire        batBelowShort,
	input wire        inputSupplyPresent,
	input wire        ldoActive,
	input wire        sysVoltageOk,
	input wire        batteryNodeOk,
	input wire        batAboveWeak,
	input wire        chargeEnabled,
	input wire        batteryMonitorEnable,
	// Outputs watched
	input wire [2:0]  shortVoltageSel,
	input wire [10:0] termCurrentX10,
	input wire        systemEnableOutput,
	input wire        isoSwitchDisable,
	input wire        batteryShortFault
);
	// ==========================================
	// Helpers
	logic [27:0] belowCnt;
	wire allHigh = ldoActive && sysVoltageOk && batteryNodeOk && batAboveWeak && chargeEnabled && inputSupplyPresent;
	wire allLow = !ldoActive && !sysVoltageOk && !batteryNodeOk && !batAboveWeak && chargeEnabled && inputSupplyPresent;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			belowCnt <= 28'h0000000;
		else if (!batBelowShort)
			belowCnt <= 28'h0000000;
		else if (belowCnt != 28'hfffffff)
			belowCnt <= belowCnt + 28'h0000001;
	end

	// ==========================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	fault_set_a: assert property ($rose(batteryShortFault) |-> belowCnt >= SEC_CYCLES - 28'd1)
		else $error("short fault set too early");
	fault_clear_a: assert property ($fell(batteryShortFault) |->
		!$past(scl) || !$past(scl, 2) || !$past(inputSupplyPresent) || !$past(inputSupplyPresent, 2))
		else $error("short fault cleared without cause");
	sysen_high_a: assert property (allHigh [*3] |-> systemEnableOutput)
		else $error("system enable missing");
	sysen_low_a: assert property (allLow [*3] |-> !systemEnableOutput)
		else $error("system enable unexpected");
	iso_cause_a: assert property (isoSwitchDisable |->
		$past(!inputSupplyPresent && batteryMonitorEnable && !batAboveWeak))
		else $error("isolation opened without cause");
	iso_follow_a: assert property (isoSwitchDisable |-> systemEnableOutput)
		else $error("isolation open without system enable");
	iso_supply_a: assert property (inputSupplyPresent [*3] |-> !isoSwitchDisable)
		else $error("isolation open with supply present");
	term_clamp_a: assert property (termCurrentX10 >= 11'd125 && termCurrentX10 <= 11'd1700)
		else $error("termination current out of range");
	volt_write_a: assert property ($changed(shortVoltageSel) |-> !$past(scl) || !$past(scl, 2) || !$past(scl, 3))
		else $error("short voltage changed without bus write");

	// ==========================================
	// Cover
	cover property ($rose(batteryShortFault));
	cover property ($rose(isoSwitchDisable));
	cover property ($fell(batteryShortFault) && inputSupplyPresent);
endmodule // cstc_charger_cfg_properties

bind cstc_charger_cfg cstc_charger_cfg_properties #(.SEC_CYCLES(SEC_CYCLES)) cstc_charger_cfg_properties_inst (
	.clk(clk), .reset_n(reset_n), .scl(scl), .batBelowShort(batBelowShort),
	.inputSupplyPresent(inputSupplyPresent), .ldoActive(ldoActive), .sysVoltageOk(sysVoltageOk),
	.batteryNodeOk(batteryNodeOk), .batAboveWeak(batAboveWeak), .chargeEnabled(chargeEnabled),
	.batteryMonitorEnable(batteryMonitorEnable), .shortVoltageSel(shortVoltageSel),
	.termCurrentX10(termCurrentX10), .systemEnableOutput(systemEnableOutput),
	.isoSwitchDisable(isoSwitchDisable), .batteryShortFault(batteryShortFault));

// [verification/charger_short_and_termination_cfg_tb_top.sv]
// Self-checking bench for the charger short and termination configuration block
`timescale 1ns/1ps
`include "cstc_defs.vh"

module charger_short_and_termination_cfg_tb_top;
	// ==========================================
	// Signals
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        batBelowShort = 1'b0;
	logic [6:0]  ana = 7'h7f;
	logic [4:0]  ichgSel = 5'h00;
	wire         scl;
	wire         hostLow;
	wire         sdaOe;
	wire         sdaOut;
	wire         sdaLine = hostLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);
	wire  [2:0]  shortVoltageSel;
	wire  [10:0] termCurrentX10;
	wire         systemEnableOutput;
	wire         isoSwitchDisable;
	wire         batteryShortFault;
	int          failures = 0;
	int          samples_checked = 0;
	int          m;
	int          i;
	logic [7:0]  d;
	logic        en;
	logic [10:0] tbl [8] = '{11'd125, 11'd325, 11'd525, 11'd725, 11'd925, 11'd1175, 11'd1425, 11'd1700};
	logic [23:0] rc [7] = '{{8'h10, 5'h00, 11'd125}, {8'h1c, 5'h1f, 11'd825}, {8'hec, 5'h1f, 11'd1650},
		{8'he4, 5'h1f, 11'd1700}, {8'h14, 5'h04, 11'd150}, {8'h08, 5'h04, 11'd300}, {8'h04, 5'h04, 11'd600}};

	always #2.5 clk = ~clk;

	// ==========================================
	// Design and host
	cstc_charger_cfg #(.SEC_CYCLES(28'd10)) cstc_charger_cfg_inst (
		.clk(clk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.batBelowShort(batBelowShort), .inputSupplyPresent(ana[1]), .ldoActive(ana[6]), .sysVoltageOk(ana[5]),
		.batteryNodeOk(ana[4]), .batAboveWeak(ana[3]), .chargeEnabled(ana[2]), .batteryMonitorEnable(ana[0]),
		.fastChargeCurrentSel(ichgSel), .shortVoltageSel(shortVoltageSel), .termCurrentX10(termCurrentX10),
		.systemEnableOutput(systemEnableOutput), .isoSwitchDisable(isoSwitchDisable),
		.batteryShortFault(batteryShortFault));
	cstc_host_model cstc_host_model_inst (.clk(clk), .scl(scl), .sdaLow(hostLow), .sdaLine(sdaLine));

	// ==========================================
	// Tasks
	task chk(input [10:0] got, input [10:0] exp);
		begin
			samples_checked++;
			if (got !== exp) begin
				failures++;
				$display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
			end
		end
	endtask

	task cyc(input int n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask

	task wr(input [7:0] a, input [7:0] v);
		logic [7:0] q;
		logic [2:0] k;
		begin
			cstc_host_model_inst.start;
			cstc_host_model_inst.xbyte({`CSTC_DEV_ADDR, 1'b0}, 1'b1, q, k[0]);
			cstc_host_model_inst.xbyte(a, 1'b1, q, k[1]);
			cstc_host_model_inst.xbyte(v, 1'b1, q, k[2]);
			cstc_host_model_inst.stop;
			chk(k, 3'h0);
		end
	endtask

	task rd(input [7:0] a, output [7:0] q);
		logic [2:0] k;
		logic n;
		begin
			cstc_host_model_inst.start;
			cstc_host_model_inst.xbyte({`CSTC_DEV_ADDR, 1'b0}, 1'b1, q, k[0]);
			cstc_host_model_inst.xbyte(a, 1'b1, q, k[1]);
			cstc_host_model_inst.start;
			cstc_host_model_inst.xbyte({`CSTC_DEV_ADDR, 1'b1}, 1'b1, q, k[2]);
			cstc_host_model_inst.xbyte(8'hff, 1'b1, q, n);
			cstc_host_model_inst.stop;
			chk(k, 3'h0);
		end
	endtask

	task close_out;
		begin
			if (failures == 0 && samples_checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// ==========================================
	// Watchdog
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		close_out;
	end

	// ==========================================
	// Tests
	initial begin
		cyc(12);
		reset_n = 1'b1;
		cyc(2);
		chk(shortVoltageSel, 3'h4);
		chk(termCurrentX10, 11'd525);
		rd(`CSTC_ADDR_SHORT_CFG, d);
		chk(d, 8'h84);
		rd(`CSTC_ADDR_TERM_CFG, d);
		chk(d, 8'h40);
		rd(`CSTC_ADDR_FAULT, d);
		chk(d, 8'h00);
		rd(8'h20, d);
		chk(d, 8'h00);
		wr(`CSTC_ADDR_SHORT_CFG, 8'hff);
		rd(`CSTC_ADDR_SHORT_CFG, d);
		chk(d, 8'he7);
		chk(shortVoltageSel, 3'h7);
		for (i = 0; i < 8; i++) begin
			wr(`CSTC_ADDR_TERM_CFG, {i[2:0], 5'h00});
			cyc(2);
			chk(termCurrentX10, tbl[i]);
		end
		for (i = 0; i < 7; i++) begin
			ichgSel = rc[i][15:11];
			wr(`CSTC_ADDR_TERM_CFG, rc[i][23:16]);
			cyc(2);
			chk(termCurrentX10, rc[i][10:0]);
		end
		for (m = 0; m < 4; m++) begin
			wr(`CSTC_ADDR_TERM_CFG, m[7:0]);
			for (i = 0; i < 128; i++) begin
				ana = i[6:0];
				cyc(3);
				if (m == 1)
					en = ana[4];
				else if (m == 3)
					en = ana[2] ? ana[3] : ana[6];
				else if (m == 2 && !ana[1] && ana[0])
					en = !ana[3];
				else
					en = ana[6] & ana[5];
				chk(systemEnableOutput, en);
				chk(isoSwitchDisable, m == 2 && !ana[1] && ana[0] && !ana[3]);
			end
		end
		wr(`CSTC_ADDR_SHORT_CFG, 8'h04);
		batBelowShort = 1'b1;
		cyc(9);
		batBelowShort = 1'b0;
		cyc(3);
		chk(batteryShortFault, 1'b0);
		for (m = 0; m < 2; m++) begin
			batBelowShort = 1'b1;
			cyc(8);
			chk(batteryShortFault, 1'b0);
			cyc(6);
			chk(batteryShortFault, 1'b1);
			batBelowShort = 1'b0;
			rd(`CSTC_ADDR_FAULT, d);
			chk(d, 8'h08);
			wr(`CSTC_ADDR_FAULT, 8'h00);
			chk(batteryShortFault, 1'b1);
			if (m == 0)
				wr(`CSTC_ADDR_FAULT, 8'h08);
			else
				ana[1] = 1'b0;
			cyc(3);
			chk(batteryShortFault, 1'b0);
			ana = 7'h7f;
		end
		wr(`CSTC_ADDR_SHORT_CFG, 8'h24);
		batBelowShort = 1'b1;
		cyc(19);
		chk(batteryShortFault, 1'b0);
		cyc(2);
		chk(batteryShortFault, 1'b1);
		batBelowShort = 1'b0;
		close_out;
	end
endmodule // charger_short_and_termination_cfg_tb_top
